// ==== eipi_top.sv ====
// Purpose: Pin-level side of the maskable external interrupt unit.
// Assumes: Processor logic on ref_clk pulses cpu_int_ack to fetch a vector.
// Notes: Pins two and three are two-way; cascade reuses both, slave reuses pin three.

`timescale 1ns/1ps

module eipi_top
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic ext_request_zero,
    input wire logic ext_request_one,
    input wire logic ext_request_two_in,
    output logic ext_request_two_out,
    output logic ext_request_two_oe,
    input wire logic ext_request_three_in,
    output logic ext_request_three_out,
    output logic ext_request_three_oe,
    input wire logic ext_request_four,
    input wire logic [7:0] ad_bus_in,
    input wire logic own_req,
    input wire logic cpu_int_ack,
    output logic cpu_int_req,
    output logic [7:0] cpu_vector,
    output logic cpu_vector_valid
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [4:0] cfg_trig;
        logic [1:0] cfg_casc;
        logic cfg_slave;
        logic [4:0] mask;
        logic [4:0] status;
        logic [4:0] edge_pend;
        logic [4:0] req_prev;
        logic [7:0] vec_base;
        logic [7:0] last_vec;
        eipi_pkg::eipi_fsm_t fsm;
        logic [2:0] src;
        logic [7:0] cnt;
        logic [31:0] rdata;
        logic wait_r;
        logic irq;
        logic int_req;
        logic [7:0] vec;
        logic vec_valid;
        logic ack0;
        logic ack1;
        logic slave_irq;
        logic pin3_out;
    } eipi_st_t;

    localparam eipi_st_t ST_RST = '{
        cfg_trig: eipi_pkg::TRIG_RST,
        mask: eipi_pkg::MASK_RST,
        vec_base: eipi_pkg::VBASE_RST,
        fsm: eipi_pkg::S_IDLE,
        wait_r: 1'b1,
        default: '0
    };

    eipi_st_t st_reg;
    eipi_st_t st_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Lowest index wins; input zero has the highest priority
    function automatic logic [2:0] first_set(input logic [4:0] v);
        logic [2:0] idx;
        idx = eipi_pkg::SPUR_IDX;
        for (int i = 4; i >= 0; i--)
        begin
            if (v[i])
                idx = 3'(i);
        end
        return idx;
    endfunction

    // Vector table entry for one input
    function automatic logic [7:0] vec_of(input logic [7:0] base, input logic [2:0] idx);
        return base + {5'h00, idx};
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [13:0] pins_async;
    logic [13:0] pins_sync;
    logic [4:0] s_req;
    logic s_sel;
    logic [7:0] s_bus;

    // Pin one doubles as type-select in slave mode
    assign pins_async = {ad_bus_in, ext_request_one, ext_request_four,
                         ext_request_three_in, ext_request_two_in,
                         ext_request_one, ext_request_zero};

    eipi_sync #(.W(14)) u_sync
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in(pins_async),
        .sync_out(pins_sync)
    );

    assign s_req = pins_sync[4:0];
    assign s_sel = pins_sync[5];
    assign s_bus = pins_sync[13:6];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [4:0] usable;
    logic [4:0] rise;
    logic [4:0] detect;
    logic [4:0] pending;
    logic [4:0] eligible;
    logic [4:0] pend_clr;
    logic [4:0] stat_clr;
    logic [2:0] pick;
    logic wr_hit;
    logic rd_hit;

    always_comb
    begin
        st_next = st_reg;
        pend_clr = 5'h00;
        stat_clr = 5'h00;
        st_next.vec_valid = 1'b0;

        // Inputs given over to cascade or slave duty take no requests
        usable = 5'h1f;
        if (st_reg.cfg_casc[0])
            usable[2] = 1'b0;
        if (st_reg.cfg_casc[1])
            usable[3] = 1'b0;
        if (st_reg.cfg_slave)
            usable = 5'h01;

        // Edge mode latches a rising edge; level mode follows the pin
        rise = s_req & ~st_reg.req_prev;
        st_next.req_prev = s_req;
        detect = ((st_reg.cfg_trig & s_req) | (~st_reg.cfg_trig & rise)) & usable;
        pending = ((st_reg.cfg_trig & s_req) | (~st_reg.cfg_trig & st_reg.edge_pend))
                  & usable;
        eligible = pending & ~st_reg.mask;
        pick = first_set(eligible);

        // Bus handshake: answer one cycle after the request appears
        wr_hit = avs_write && !st_reg.wait_r;
        rd_hit = avs_read && !st_reg.wait_r;
        st_next.wait_r = !((avs_read || avs_write) && st_reg.wait_r);

        // Read data sampled in the request cycle, stands at the answer
        if (avs_read && st_reg.wait_r)
        begin
            case (avs_address)
                eipi_pkg::ADDR_CTRL:
                    st_next.rdata = {21'h000000, st_reg.cfg_slave, st_reg.cfg_casc,
                                     3'h0, st_reg.cfg_trig};
                eipi_pkg::ADDR_MASK:
                    st_next.rdata = {27'h0000000, st_reg.mask};
                eipi_pkg::ADDR_STATUS:
                    st_next.rdata = {27'h0000000, st_reg.status};
                eipi_pkg::ADDR_PEND:
                    st_next.rdata = {27'h0000000, pending};
                eipi_pkg::ADDR_VBASE:
                    st_next.rdata = {24'h000000, st_reg.vec_base};
                eipi_pkg::ADDR_LASTV:
                    st_next.rdata = {24'h000000, st_reg.last_vec};
                default:
                    st_next.rdata = 32'h00000000;
            endcase
        end

        // Register writes; unmapped addresses are ignored
        if (wr_hit)
        begin
            case (avs_address)
                eipi_pkg::ADDR_CTRL:
                begin
                    st_next.cfg_trig = avs_writedata[eipi_pkg::CTRL_TRIG_LSB +: 5];
                    st_next.cfg_casc[0] = avs_writedata[eipi_pkg::CTRL_CASC0_BIT];
                    st_next.cfg_casc[1] = avs_writedata[eipi_pkg::CTRL_CASC1_BIT];
                    st_next.cfg_slave = avs_writedata[eipi_pkg::CTRL_SLAVE_BIT];
                end
                eipi_pkg::ADDR_MASK:
                    st_next.mask = avs_writedata[4:0];
                eipi_pkg::ADDR_VBASE:
                    st_next.vec_base = avs_writedata[7:0];
                default:
                    st_next.vec_base = st_reg.vec_base;
            endcase
        end

        // Reading status clears it at the answer edge
        if (rd_hit && avs_address == eipi_pkg::ADDR_STATUS)
            stat_clr = 5'h1f;

        // Vector fetch sequencer
        case (st_reg.fsm)
            eipi_pkg::S_IDLE:
            begin
                if (cpu_int_ack)
                begin
                    st_next.cnt = 8'h00;
                    if (st_reg.cfg_slave)
                    begin
                        // Master already raised request zero; wait for type-select
                        st_next.src = 3'h0;
                        pend_clr[0] = 1'b1;
                        st_next.fsm = eipi_pkg::S_SEL;
                    end
                    else if (eligible != 5'h00)
                    begin
                        st_next.src = pick;
                        pend_clr[pick] = 1'b1;
                        if (pick == 3'h0 && st_reg.cfg_casc[0])
                        begin
                            st_next.ack0 = 1'b1;
                            st_next.fsm = eipi_pkg::S_CASC;
                        end
                        else if (pick == 3'h1 && st_reg.cfg_casc[1])
                        begin
                            st_next.ack1 = 1'b1;
                            st_next.fsm = eipi_pkg::S_CASC;
                        end
                        else
                        begin
                            st_next.vec = vec_of(st_reg.vec_base, pick);
                            st_next.vec_valid = 1'b1;
                        end
                    end
                    else
                    begin
                        // Request withdrawn before the fetch: spurious entry
                        st_next.vec = vec_of(st_reg.vec_base, eipi_pkg::SPUR_IDX);
                        st_next.vec_valid = 1'b1;
                    end
                end
            end
            eipi_pkg::S_CASC:
            begin
                // Fixed window covers pin drive plus two sync stages
                if (st_reg.cnt == eipi_pkg::CASC_ACK_CYCLES - 8'h01)
                begin
                    st_next.vec = s_bus;
                    st_next.vec_valid = 1'b1;
                    st_next.ack0 = 1'b0;
                    st_next.ack1 = 1'b0;
                    st_next.fsm = eipi_pkg::S_IDLE;
                end
                else
                    st_next.cnt = st_reg.cnt + 8'h01;
            end
            eipi_pkg::S_SEL:
            begin
                if (s_sel)
                begin
                    st_next.vec = s_bus;
                    st_next.vec_valid = 1'b1;
                    st_next.fsm = eipi_pkg::S_IDLE;
                end
                else if (st_reg.cnt == eipi_pkg::SEL_TIMEOUT_CYCLES - 8'h01)
                begin
                    // A silent master must not hang the processor
                    st_next.vec = vec_of(st_reg.vec_base, eipi_pkg::SPUR_IDX);
                    st_next.vec_valid = 1'b1;
                    st_next.fsm = eipi_pkg::S_IDLE;
                end
                else
                    st_next.cnt = st_reg.cnt + 8'h01;
            end
            default:
                st_next.fsm = eipi_pkg::S_IDLE;
        endcase

        if (st_next.vec_valid)
            st_next.last_vec = st_next.vec;

        // Set wins over clear for latched edges and sticky status
        st_next.edge_pend = ((st_reg.edge_pend & ~pend_clr) | (rise & ~st_reg.cfg_trig))
                            & usable;
        st_next.status = (st_reg.status & ~stat_clr) | detect;

        // Outputs computed here so they leave a flop; irq and pin three use the next state, int_req the current one
        st_next.int_req = (st_reg.fsm == eipi_pkg::S_IDLE) && !cpu_int_ack
                          && (eligible != 5'h00);
        st_next.irq = (st_next.status & ~st_next.mask) != 5'h00;
        st_next.slave_irq = st_next.cfg_slave && own_req;
        st_next.pin3_out = st_next.cfg_casc[1] ? st_next.ack1 : st_next.slave_irq;
    end

    // Register the state
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            st_reg <= ST_RST;
        else
            st_reg <= st_next;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_readdata = st_reg.rdata;
    assign avs_waitrequest = st_reg.wait_r;
    assign irq = st_reg.irq;
    assign cpu_int_req = st_reg.int_req;
    assign cpu_vector = st_reg.vec;
    assign cpu_vector_valid = st_reg.vec_valid;
    assign ext_request_two_out = st_reg.ack0;
    assign ext_request_two_oe = st_reg.cfg_casc[0];
    assign ext_request_three_out = st_reg.pin3_out;
    assign ext_request_three_oe = st_reg.cfg_casc[1] | st_reg.cfg_slave;

endmodule

// ==== eipi_pkg.sv ====
// Purpose: Shared constants for the external interrupt pin interface.
// Assumes: Word-addressed Avalon-MM slave, one register per 32-bit word.
// Notes: All offsets are word indices on avs_address.

package eipi_pkg;

    // ------------------------------------------------------------
    // Register map (word index)
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_MASK = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_PEND = 3'h3;
    localparam logic [2:0] ADDR_VBASE = 3'h4;
    localparam logic [2:0] ADDR_LASTV = 3'h5;

    // ------------------------------------------------------------
    // Field positions in the control word
    // ------------------------------------------------------------
    localparam int CTRL_TRIG_LSB = 0;
    localparam int CTRL_CASC0_BIT = 8;
    localparam int CTRL_CASC1_BIT = 9;
    localparam int CTRL_SLAVE_BIT = 10;

    // ------------------------------------------------------------
    // Values after reset, and the spurious vector index
    // ------------------------------------------------------------
    localparam logic [4:0] TRIG_RST = 5'h00;
    localparam logic [4:0] MASK_RST = 5'h1f;
    localparam logic [7:0] VBASE_RST = 8'h0c;
    localparam logic [2:0] SPUR_IDX = 3'h7;

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [7:0] CASC_ACK_CYCLES = 8'h04;
    localparam logic [7:0] SEL_TIMEOUT_CYCLES = 8'hff;

    // ------------------------------------------------------------
    // Vector fetch sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        S_IDLE,
        S_CASC,
        S_SEL
    } eipi_fsm_t;

endpackage

// ==== eipi_sync.sv ====
// Purpose: Two-stage synchroniser for asynchronous pin inputs.
// Assumes: Multi-bit inputs are held stable by the far side while used.
// Notes: Only the second stage leaves this module.

`timescale 1ns/1ps

module eipi_sync
#(
    parameter int W = 14
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } eipi_sync_st_t;

    eipi_sync_st_t sync_reg;
    eipi_sync_st_t sync_next;

    // Stage one feeds stage two and nothing else
    always_comb
    begin
        sync_next = sync_reg;
        sync_next.stage1 = async_in;
        sync_next.stage2 = sync_reg.stage1;
    end

    // Register the state
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            sync_reg <= '0;
        else
            sync_reg <= sync_next;
    end

    assign sync_out = sync_reg.stage2;

endmodule

// ==== eipi_top_assertions.sv ====
// Purpose: Port-level checks of the interrupt pin interface.
// Assumes: One clock, rst_b synchronous active low.
// Notes: Internal registers are unseen; checks tie outputs to inputs.
`timescale 1ns/1ps

module eipi_checker
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic ext_request_two_out,
    input wire logic ext_request_two_oe,
    input wire logic ext_request_three_out,
    input wire logic ext_request_three_oe,
    input wire logic cpu_int_ack,
    input wire logic cpu_int_req,
    input wire logic [7:0] cpu_vector,
    input wire logic cpu_vector_valid
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    // Each access answers after exactly one wait cycle
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait");
    wait_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without access");
    ack_cause_a: assert property ($rose(ext_request_two_out) |-> $past(cpu_int_ack))
        else $error("acknowledge pin without vector fetch");
    ack_end_a: assert property ($rose(ext_request_two_out)
        |-> ext_request_two_out [*4] ##1 !ext_request_two_out)
        else $error("acknowledge pin stuck");
    ack_vec_a: assert property ($fell(ext_request_two_out) |-> cpu_vector_valid)
        else $error("acknowledge ended without vector");
    two_oe_a: assert property (ext_request_two_out |-> ext_request_two_oe)
        else $error("pin two driven while input");
    three_oe_a: assert property (ext_request_three_out |-> ext_request_three_oe)
        else $error("pin three driven while input");
    valid_pulse_a: assert property (cpu_vector_valid |=> !cpu_vector_valid)
        else $error("vector valid longer than one cycle");
    req_drop_a: assert property (cpu_int_ack && cpu_int_req |=> !cpu_int_req)
        else $error("request not dropped after fetch");
    norm_vec_a: assert property (cpu_int_ack && cpu_int_req && !ext_request_two_oe
        && !ext_request_three_oe |=> cpu_vector_valid)
        else $error("plain vector late");
    vec_change_a: assert property ($changed(cpu_vector) |-> cpu_vector_valid)
        else $error("vector changed without valid");
    // Main scenarios reached
    cover property (cpu_vector_valid && ext_request_two_oe);
    cover property (ext_request_three_oe && ext_request_three_out);
    cover property (cpu_int_ack && !cpu_int_req);
endmodule

bind eipi_top eipi_checker u_eipi_checker (.ref_clk(ref_clk), .rst_b(rst_b),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .ext_request_two_out(ext_request_two_out), .ext_request_two_oe(ext_request_two_oe),
    .ext_request_three_out(ext_request_three_out), .ext_request_three_oe(ext_request_three_oe),
    .cpu_int_ack(cpu_int_ack), .cpu_int_req(cpu_int_req), .cpu_vector(cpu_vector),
    .cpu_vector_valid(cpu_vector_valid));

// ==== eipi_far.sv ====
// Purpose: Requesting peripherals and master controller at the pins.
// Assumes: Bench pulses raise; requests drop once a vector goes out.
// Notes: Released bus toggles every cycle, never keeps a stale type.
`timescale 1ns/1ps

module eipi_far
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [4:0] raise,
    input wire logic slave,
    input wire logic [7:0] type_val,
    input wire logic two_out,
    input wire logic two_oe,
    input wire logic three_out,
    input wire logic three_oe,
    input wire logic vec_valid,
    output logic [4:0] pin,
    output logic [7:0] ad_bus
);
    logic [4:0] pend;
    logic [2:0] cnt;
    logic [7:0] ad_last;
    logic sel;
    logic drive;
    // Requests stand until a vector goes out; select waits on request zero
    always_ff @(posedge ref_clk)
    begin
        ad_last <= rst_b ? ad_bus : 8'h00;
        pend <= (!rst_b || vec_valid) ? 5'h00 : pend | raise;
        cnt <= (!rst_b || !slave || !pend[0]) ? 3'h0 : cnt + 3'(cnt != 3'h7);
    end
    assign sel = slave && cnt == 3'h7;
    // Type only while asked for
    assign drive = sel || (two_oe && two_out) || (three_oe && three_out && !slave);
    assign ad_bus = drive ? type_val : ~ad_last;
    // Two-way pins follow whoever holds the enable
    assign pin = {pend[4], three_oe ? three_out : pend[3], two_oe ? two_out : pend[2],
        slave ? sel : pend[1], pend[0]};
endmodule

// ==== test_external_interrupt_pin_interface.sv ====
// Purpose: Self-checking bench for the interrupt pin interface.
// Assumes: Far side model drives pins; bench is bus master and processor.
// Notes: Vector base moves to 8'h40 midway to test the offset.
`timescale 1ns/1ps

module test_external_interrupt_pin_interface;
    logic ref_clk;
    logic rst_b;
    logic [2:0] addr;
    logic rd, wr, wait_r, irq, ack, int_req, vvalid, own_req, slave;
    logic two_out, two_oe, three_out, three_oe;
    logic [31:0] wdata, rdata, q;
    logic [4:0] pin, raise;
    logic [7:0] ad, vec, typ, vb;
    int error_cnt;
    int n_tests;
    int k;

    eipi_top u_eipi_top (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wait_r), .irq(irq), .ext_request_zero(pin[0]),
        .ext_request_one(pin[1]), .ext_request_two_in(pin[2]), .ext_request_two_out(two_out),
        .ext_request_two_oe(two_oe), .ext_request_three_in(pin[3]),
        .ext_request_three_out(three_out), .ext_request_three_oe(three_oe),
        .ext_request_four(pin[4]), .ad_bus_in(ad), .own_req(own_req), .cpu_int_ack(ack),
        .cpu_int_req(int_req), .cpu_vector(vec), .cpu_vector_valid(vvalid));
    eipi_far u_eipi_far (.ref_clk(ref_clk), .rst_b(rst_b), .raise(raise), .slave(slave),
        .type_val(typ), .two_out(two_out), .two_oe(two_oe), .three_out(three_out),
        .three_oe(three_oe), .vec_valid(vvalid), .pin(pin), .ad_bus(ad));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do @(posedge ref_clk); while (wait_r !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge ref_clk);
        raise <= 5'h01 << i;
        @(posedge ref_clk);
        raise <= 5'h00;
    endtask
    // Fetch a vector; k counts cycles an acknowledge pin stood high
    task automatic take(input logic [7:0] exp);
        int n;
        n = 0;
        k = 0;
        do @(posedge ref_clk); while (int_req !== 1'b1 && ++n < 40);
        ack <= 1'b1;
        @(posedge ref_clk);
        ack <= 1'b0;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            k += int'(two_out === 1'b1 || three_out === 1'b1);
        end
        while (vvalid !== 1'b1 && ++n < 300);
        chk({31'h0, vvalid}, 32'h1);
        chk({24'h0, vec}, {24'h0, exp});
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rchk(eipi_pkg::ADDR_CTRL, 32'h0);
        rchk(eipi_pkg::ADDR_MASK, {27'h0, eipi_pkg::MASK_RST});
        rchk(eipi_pkg::ADDR_VBASE, {24'h0, eipi_pkg::VBASE_RST});
        bus(1'b1, 3'h6, 32'hffffffff);
        rchk(3'h6, 32'h0);
        bus(1'b1, eipi_pkg::ADDR_MASK, 32'hffffffe0);
        rchk(eipi_pkg::ADDR_MASK, 32'h0);
    endtask
    task automatic t_edge();
        for (int i = 0; i < 5; i++)
        begin
            pulse(i);
            take(vb + 8'(i));
            chk({31'h0, irq}, 32'h1);
            rchk(eipi_pkg::ADDR_STATUS, 32'h1 << i);
            repeat (3) @(posedge ref_clk);
            chk({31'h0, irq}, 32'h0);
        end
    endtask
    // Masked request waits, then comes out once unmasked
    task automatic t_mask();
        bus(1'b1, eipi_pkg::ADDR_MASK, 32'h10);
        pulse(4);
        take(vb + 8'h07);
        chk({30'h0, irq, int_req}, 32'h0);
        rchk(eipi_pkg::ADDR_STATUS, 32'h10);
        bus(1'b1, eipi_pkg::ADDR_MASK, 32'h0);
        take(vb + 8'h04);
    endtask
    task automatic t_level();
        bus(1'b1, eipi_pkg::ADDR_VBASE, 32'h40);
        vb = 8'h40;
        bus(1'b1, eipi_pkg::ADDR_CTRL, 32'h08);
        pulse(3);
        take(8'h43);
        repeat (6) @(posedge ref_clk);
        bus(1'b0, eipi_pkg::ADDR_STATUS, 32'h0);
        rchk(eipi_pkg::ADDR_PEND, 32'h0);
    endtask
    task automatic t_cascade();
        for (int j = 0; j < 2; j++)
        begin
            bus(1'b1, eipi_pkg::ADDR_CTRL, 32'h100 << j);
            typ <= 8'h5a + 8'(j);
            repeat (2) @(posedge ref_clk);
            chk({31'h0, ((j != 0) ? three_oe : two_oe)}, 32'h1);
            pulse(j);
            take(8'h5a + 8'(j));
            chk(32'(k), {24'h0, eipi_pkg::CASC_ACK_CYCLES});
            repeat (4) @(posedge ref_clk);
        end
    endtask
    task automatic t_slave();
        bus(1'b1, eipi_pkg::ADDR_CTRL, 32'h400);
        slave <= 1'b1;
        own_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk({30'h0, three_oe, three_out}, 32'h3);
        own_req <= 1'b0;
        typ <= 8'h3c;
        repeat (3) @(posedge ref_clk);
        chk({30'h0, three_oe, three_out}, 32'h2);
        pulse(0);
        take(8'h3c);
        rchk(eipi_pkg::ADDR_LASTV, 32'h3c);
    endtask

    // ----------------------------------------
    // Clock, sequence and watchdog
    // ----------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        {rst_b, rd, wr, ack, own_req, slave} = 6'h00;
        addr = 3'h0;
        wdata = 32'h0;
        raise = 5'h00;
        typ = 8'h00;
        vb = eipi_pkg::VBASE_RST;
        error_cnt = 0;
        n_tests = 0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_regs();
        t_edge();
        t_mask();
        t_level();
        t_cascade();
        t_slave();
        complete_run();
    end
    // Whole run needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        complete_run();
    end
endmodule
